// ---- common/dacc_pkg.sv ----
package dacc_pkg;

  // ****************************************************************
  // Alarm slots
  // ****************************************************************
  localparam int NUM_ALARMS = 37;
  localparam int CODE_W     = 10;
  localparam int PARAM_W    = 16;

  // Slot indices that the clearing logic singles out
  localparam int S_OVERCUR  = 0;
  localparam int S_OVERVOLT = 1;
  localparam int S_UNDERVOLT = 2;
  localparam int S_MAGFIELD = 3;
  localparam int S_ENCODER  = 9;
  localparam int S_ADJUST   = 10;
  localparam int S_EMGS     = 11;
  localparam int S_REVLIM   = 12;
  localparam int S_FWDLIM   = 13;
  localparam int S_NVM      = 15;
  localparam int S_TEMPWARN = 31;
  localparam int S_FWUP     = 34;
  localparam int S_PROC_A   = 35;
  localparam int S_PROC_B   = 36;

  // ****************************************************************
  // Parameter fields and reset values
  // ****************************************************************
  localparam int                 FOPT_AUTO_UV_BIT = 2;
  localparam logic [PARAM_W-1:0] FOPT_RESET       = 16'h0000;
  localparam logic [PARAM_W-1:0] SFP_FW_STEP1     = 16'h001e;  // Decimal 30
  localparam logic [PARAM_W-1:0] SFP_FW_STEP2     = 16'h001c;  // Decimal 28
  localparam logic [CODE_W-1:0]  CODE_NONE        = 10'h000;

  // ****************************************************************
  // Clearing policies
  // ****************************************************************
  typedef enum logic [3:0] {
    CLR_ARST      = 4'b0000,  // Alarm reset edge
    CLR_ARST_INIT = 4'b0001,  // Alarm reset edge or initialisation
    CLR_UNDERV    = 4'b0010,  // Auto on good voltage, else reset edge
    CLR_INIT      = 4'b0011,  // Initialisation only
    CLR_ADJUST    = 4'b0100,  // Auto adjustment completion
    CLR_EMGS      = 4'b0101,  // Follows emergency stop input
    CLR_REVLIM    = 4'b0110,  // Reset, servo off, or forward motion
    CLR_FWDLIM    = 4'b0111,  // Reset, servo off, or reverse motion
    CLR_NVM       = 4'b1000,  // Origin dependent sequence
    CLR_SELF      = 4'b1001,  // Follows its own cause
    CLR_FWUP      = 4'b1010,  // Armed parameter sequence then init
    CLR_NONE      = 4'b1011   // Never clears
  } dacc_policy_t;

  // Per slot alarm code as displayed to the operator
  localparam logic [CODE_W-1:0] ALARM_CODE [NUM_ALARMS] = '{
    10'd1, 10'd2, 10'd3, 10'd4, 10'd5, 10'd6, 10'd7, 10'd8, 10'd9, 10'd11,
    10'd12, 10'd13, 10'd14, 10'd15, 10'd16, 10'd17, 10'd18, 10'd19, 10'd20,
    10'd22, 10'd23, 10'd24, 10'd25, 10'd26, 10'd27, 10'd28, 10'd29, 10'd30,
    10'd31, 10'd35, 10'd48, 10'd67, 10'd83, 10'd85, 10'd99, 10'd555, 10'd880};

  // Per slot clearing policy
  localparam dacc_policy_t ALARM_POLICY [NUM_ALARMS] = '{
    CLR_ARST, CLR_ARST_INIT, CLR_UNDERV, CLR_INIT, CLR_ARST, CLR_ARST,
    CLR_ARST, CLR_ARST, CLR_ARST, CLR_INIT, CLR_ADJUST, CLR_EMGS,
    CLR_REVLIM, CLR_FWDLIM, CLR_ARST, CLR_NVM, CLR_ARST, CLR_ARST,
    CLR_ARST, CLR_ARST, CLR_ARST, CLR_INIT, CLR_INIT, CLR_INIT, CLR_INIT,
    CLR_INIT, CLR_INIT, CLR_ARST, CLR_INIT, CLR_INIT, CLR_ARST, CLR_SELF,
    CLR_ARST, CLR_ARST, CLR_FWUP, CLR_NONE, CLR_NONE};

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic alarm_reset_input;     // Machine controller alarm reset
    logic emergency_stop_input;  // Emergency stop level
    logic servo_on;              // Servo enable level
    logic power_on_init;         // One-cycle initialisation event
    logic startup_phase;         // High during drive start-up
    logic voltage_ok;            // Supply measurement in range
    logic motor_moving_fwd;      // Motor turning forward
    logic motor_moving_rev;      // Motor turning in reverse
    logic auto_adjust_done;      // One-cycle adjustment completion
    logic param_reset_done;      // One-cycle parameter reset event
  } dacc_ctrl_t;

  typedef struct packed {
    logic               fault_option_wr;      // Write strobe
    logic               special_function_wr;  // Write strobe
    logic [PARAM_W-1:0] data;                 // Write data
  } dacc_param_wr_t;

  typedef enum logic [1:0] {
    NVM_IDLE       = 2'b00,
    NVM_WAIT_RESET = 2'b01,
    NVM_WAIT_SERVO = 2'b10
  } dacc_nvm_state_t;

  typedef enum logic [1:0] {
    FW_IDLE  = 2'b00,
    FW_GOT30 = 2'b01,
    FW_ARMED = 2'b10
  } dacc_fw_state_t;

endpackage

// ---- hdl/dacc_alarm_latch.sv ----
`timescale 1ns/1ps
// Sticky alarm bits; a set in the same cycle as a clear wins
module dacc_alarm_latch #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Events
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  // State
  output logic      [W-1:0] q
);

  // Set has priority so no detection is lost on a clear cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= set | (q & ~clr);
    end
  end

  set_wins_a: assert property (@(posedge clk) disable iff (rst)
    (set != '0) |=> ((q & $past(set)) == $past(set)))
    else $error("Alarm set lost against clear");

endmodule

// ---- hdl/dacc_clear_ctrl.sv ----
`timescale 1ns/1ps
// Behaviour
// [RULE1] Reset-class alarms clear on alarm reset
// [RULE2] Encoder and wiring alarms clear only at init
// [RULE3] Magnetic field alarm clears only at init
// [RULE4] Over-voltage also clears at power-on init
// [RULE5] Option bit enables under-voltage self clear
// [RULE6] Adjustment alarm clears when auto adjustment completes
// [RULE7] Emergency stop alarm follows its input
// [RULE8] Limit alarms clear on reset or servo off
// [RULE9] Limit alarm clears moving away from limit
// [RULE10] Start-up memory alarm needs parameter reset, servo on
// [RULE11] Operational memory alarm clears on alarm reset
// [RULE12] Encoder temperature warning clears by itself
// [RULE13] Firmware alarm: write 30, 28, then init
// [RULE14] Processor error alarms never clear
// [RULE15] Report latched alarm code, none when clear
module dacc_clear_ctrl
  import dacc_pkg::*;
#(
  parameter int N = NUM_ALARMS
) (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rst,
  // Fault detection, one bit per alarm slot
  input  wire logic [N-1:0]   fault_detect,
  // Machine controller and drive status
  input  wire dacc_ctrl_t     ctrl,
  // Operator parameter writes
  input  wire dacc_param_wr_t param_wr,
  // Operator reporting
  output logic [N-1:0]        alarm_latched,
  output logic [CODE_W-1:0]   alarm_code_reg,
  output logic                alarm_active_reg,
  output logic [PARAM_W-1:0]  fault_option_reg
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (N != NUM_ALARMS) begin : g_bad_n
    $error("Slot count must match the alarm table");
  end

  // ****************************************************************
  // Edge detection on controller levels
  // ****************************************************************
  logic arst_prev_reg;   // Alarm reset input last cycle
  logic servo_prev_reg;  // Servo enable last cycle
  logic arst_edge;       // Alarm reset newly asserted
  logic servo_rise;      // Servo switched on
  logic servo_fall;      // Servo switched off

  // Edges keep a held reset input from clearing new alarms repeatedly
  always_ff @(posedge clk) begin
    if (rst) begin
      arst_prev_reg  <= 1'b0;
      servo_prev_reg <= 1'b0;
    end else begin
      arst_prev_reg  <= ctrl.alarm_reset_input;
      servo_prev_reg <= ctrl.servo_on;
    end
  end

  assign arst_edge  = ctrl.alarm_reset_input & ~arst_prev_reg;
  assign servo_rise = ctrl.servo_on & ~servo_prev_reg;
  assign servo_fall = ~ctrl.servo_on & servo_prev_reg;

  // ****************************************************************
  // Parameter writes
  // ****************************************************************
  dacc_fw_state_t  fw_state_reg;   // Firmware clear sequence
  dacc_fw_state_t  fw_state_next;
  logic            sfp_wr30;       // Special function write of 30
  logic            sfp_wr28;       // Special function write of 28

  // Option register steers under-voltage auto clear
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_option_reg <= FOPT_RESET;
    end else if (param_wr.fault_option_wr) begin
      fault_option_reg <= param_wr.data;
    end
  end

  assign sfp_wr30 = param_wr.special_function_wr && (param_wr.data == SFP_FW_STEP1);
  assign sfp_wr28 = param_wr.special_function_wr && (param_wr.data == SFP_FW_STEP2);

  // Order matters: 28 without a preceding 30 arms nothing
  always_comb begin
    fw_state_next = fw_state_reg;
    unique case (fw_state_reg)
      FW_IDLE: begin
        if (sfp_wr30) begin
          fw_state_next = FW_GOT30;  // [RULE13]
        end
      end
      FW_GOT30: begin
        if (sfp_wr28) begin
          fw_state_next = FW_ARMED;  // [RULE13]
        end else if (param_wr.special_function_wr && !sfp_wr30) begin
          fw_state_next = FW_IDLE;
        end
      end
      FW_ARMED: begin
        // Consumed by the initialisation that performs the clear
        if (ctrl.power_on_init) begin
          fw_state_next = FW_IDLE;
        end
      end
      default: fw_state_next = FW_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fw_state_reg <= FW_IDLE;
    end else begin
      fw_state_reg <= fw_state_next;
    end
  end

  // ****************************************************************
  // Nonvolatile memory alarm origin tracking
  // ****************************************************************
  dacc_nvm_state_t nvm_state_reg;  // Start-up recovery progress
  dacc_nvm_state_t nvm_state_next;
  logic            nvm_clear;      // Clear term for the memory alarm

  // A start-up alarm waits for parameter reset, then servo on
  always_comb begin
    nvm_state_next = nvm_state_reg;
    unique case (nvm_state_reg)
      NVM_IDLE: begin
        if (fault_detect[S_NVM] && ctrl.startup_phase) begin
          nvm_state_next = NVM_WAIT_RESET;  // [RULE10]
        end
      end
      NVM_WAIT_RESET: begin
        if (ctrl.param_reset_done) begin
          nvm_state_next = NVM_WAIT_SERVO;  // [RULE10]
        end
      end
      NVM_WAIT_SERVO: begin
        if (servo_rise) begin
          nvm_state_next = NVM_IDLE;
        end
      end
      default: nvm_state_next = NVM_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      nvm_state_reg <= NVM_IDLE;
    end else begin
      nvm_state_reg <= nvm_state_next;
    end
  end

  // Reset input only helps an alarm raised in operation
  assign nvm_clear = ((nvm_state_reg == NVM_IDLE) && arst_edge)          // [RULE11]
                   | ((nvm_state_reg == NVM_WAIT_SERVO) && servo_rise);  // [RULE10]

  // ****************************************************************
  // Per slot set and clear decoding
  // ****************************************************************
  logic [N-1:0] alarm_set;    // Detection this cycle
  logic [N-1:0] alarm_clr;    // Clearing condition this cycle
  logic         uv_auto;      // Under-voltage self clear enabled
  logic         limit_common; // Reset or servo off for limits

  assign uv_auto      = fault_option_reg[FOPT_AUTO_UV_BIT];
  assign limit_common = arst_edge | servo_fall;  // [RULE8]

  for (genvar i = 0; i < N; i++) begin : g_slot
    // Emergency stop is raised straight from its input level
    assign alarm_set[i] = fault_detect[i]
                        | ((i == S_EMGS) && ctrl.emergency_stop_input);  // [RULE7]
    assign alarm_clr[i] =
        (ALARM_POLICY[i] == CLR_ARST)      ? arst_edge :                         // [RULE1]
        (ALARM_POLICY[i] == CLR_ARST_INIT) ? (arst_edge | ctrl.power_on_init) :  // [RULE4]
        (ALARM_POLICY[i] == CLR_UNDERV)    ? (uv_auto ? ctrl.voltage_ok
                                                      : arst_edge) :             // [RULE5]
        (ALARM_POLICY[i] == CLR_INIT)      ? ctrl.power_on_init :                // [RULE2] [RULE3]
        (ALARM_POLICY[i] == CLR_ADJUST)    ? ctrl.auto_adjust_done :             // [RULE6]
        (ALARM_POLICY[i] == CLR_EMGS)      ? ~ctrl.emergency_stop_input :        // [RULE7]
        (ALARM_POLICY[i] == CLR_REVLIM)    ? (limit_common
                                              | ctrl.motor_moving_fwd) :         // [RULE9]
        (ALARM_POLICY[i] == CLR_FWDLIM)    ? (limit_common
                                              | ctrl.motor_moving_rev) :         // [RULE9]
        (ALARM_POLICY[i] == CLR_NVM)       ? nvm_clear :
        (ALARM_POLICY[i] == CLR_SELF)      ? ~fault_detect[i] :                  // [RULE12]
        (ALARM_POLICY[i] == CLR_FWUP)      ? ((fw_state_reg == FW_ARMED)
                                              & ctrl.power_on_init) :            // [RULE13]
        1'b0;                                                                    // [RULE14]
  end

  dacc_alarm_latch #(
    .W (N)
  ) u_latch (
    .clk (clk),
    .rst (rst),
    .set (alarm_set),
    .clr (alarm_clr),
    .q   (alarm_latched)
  );

  // ****************************************************************
  // Operator reporting
  // ****************************************************************
  logic [CODE_W-1:0] code_next;  // Code of lowest latched slot

  // Lowest slot wins when several alarms stand at once
  always_comb begin
    code_next = CODE_NONE;
    for (int k = N - 1; k >= 0; k--) begin
      if (alarm_latched[k]) begin
        code_next = ALARM_CODE[k];  // [RULE15]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      alarm_code_reg   <= CODE_NONE;
      alarm_active_reg <= 1'b0;
    end else begin
      alarm_code_reg   <= code_next;
      alarm_active_reg <= |alarm_latched;  // [RULE15]
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_arst_rise;
    ctrl.alarm_reset_input && !arst_prev_reg;
  endsequence

  sequence s_nvm_recovery;
    (nvm_state_reg == NVM_WAIT_SERVO) && servo_rise && !fault_detect[S_NVM];
  endsequence

  arst_clears_a: assert property (@(posedge clk) disable iff (rst)  // [RULE1]
    s_arst_rise and !fault_detect[S_OVERCUR] |=> !alarm_latched[S_OVERCUR])
    else $error("Over-current alarm survived alarm reset");

  encoder_holds_a: assert property (@(posedge clk) disable iff (rst)  // [RULE2]
    alarm_latched[S_ENCODER] && !ctrl.power_on_init |=> alarm_latched[S_ENCODER])
    else $error("Encoder alarm cleared without initialisation");

  magfield_holds_a: assert property (@(posedge clk) disable iff (rst)  // [RULE3]
    alarm_latched[S_MAGFIELD] && !ctrl.power_on_init |=> alarm_latched[S_MAGFIELD])
    else $error("Magnetic field alarm cleared without initialisation");

  overvolt_init_a: assert property (@(posedge clk) disable iff (rst)  // [RULE4]
    ctrl.power_on_init && !fault_detect[S_OVERVOLT] |=> !alarm_latched[S_OVERVOLT])
    else $error("Over-voltage alarm survived initialisation");

  undervolt_auto_a: assert property (@(posedge clk) disable iff (rst)  // [RULE5]
    fault_option_reg[FOPT_AUTO_UV_BIT] && ctrl.voltage_ok && !fault_detect[S_UNDERVOLT]
    |=> !alarm_latched[S_UNDERVOLT])
    else $error("Under-voltage alarm did not self clear");

  adjust_clear_a: assert property (@(posedge clk) disable iff (rst)  // [RULE6]
    ctrl.auto_adjust_done && !fault_detect[S_ADJUST] |=> !alarm_latched[S_ADJUST])
    else $error("Adjustment alarm survived auto adjustment");

  emgs_follow_a: assert property (@(posedge clk) disable iff (rst)  // [RULE7]
    (ctrl.emergency_stop_input |=> alarm_latched[S_EMGS]) and
    (!ctrl.emergency_stop_input && !fault_detect[S_EMGS] |=> !alarm_latched[S_EMGS]))
    else $error("Emergency stop alarm does not follow its input");

  limit_clear_a: assert property (@(posedge clk) disable iff (rst)  // [RULE8]
    (!ctrl.servo_on && servo_prev_reg) && !fault_detect[S_FWDLIM]
    |=> !alarm_latched[S_FWDLIM])
    else $error("Forward limit alarm survived servo off");

  limit_away_a: assert property (@(posedge clk) disable iff (rst)  // [RULE9]
    ctrl.motor_moving_fwd && !fault_detect[S_REVLIM] |=> !alarm_latched[S_REVLIM])
    else $error("Reverse limit alarm survived forward motion");

  nvm_startup_a: assert property (@(posedge clk) disable iff (rst)  // [RULE10]
    s_nvm_recovery |=> !alarm_latched[S_NVM] && (nvm_state_reg == NVM_IDLE))
    else $error("Memory alarm not cleared by recovery sequence");

  nvm_oper_a: assert property (@(posedge clk) disable iff (rst)  // [RULE11]
    s_arst_rise and (nvm_state_reg == NVM_IDLE) and !fault_detect[S_NVM]
    |=> !alarm_latched[S_NVM])
    else $error("Operational memory alarm survived alarm reset");

  tempwarn_self_a: assert property (@(posedge clk) disable iff (rst)  // [RULE12]
    !fault_detect[S_TEMPWARN] |=> !alarm_latched[S_TEMPWARN])
    else $error("Temperature warning did not self clear");

  fw_sequence_a: assert property (@(posedge clk) disable iff (rst)  // [RULE13]
    (fw_state_reg == FW_GOT30) && sfp_wr28 ##1 ctrl.power_on_init && !fault_detect[S_FWUP]
    |=> !alarm_latched[S_FWUP])
    else $error("Firmware alarm not cleared after armed initialisation");

  proc_hold_a: assert property (@(posedge clk) disable iff (rst)  // [RULE14]
    (alarm_latched[S_PROC_A] |=> alarm_latched[S_PROC_A]) and
    (alarm_latched[S_PROC_B] |=> alarm_latched[S_PROC_B]))
    else $error("Processor error alarm cleared");

  no_alarm_a: assert property (@(posedge clk) disable iff (rst)  // [RULE15]
    (alarm_latched == '0) |=> !alarm_active_reg && (alarm_code_reg == CODE_NONE))
    else $error("Alarm reported with nothing latched");

endmodule

// ---- test/dacc_host_model.sv ----
`timescale 1ns/1ps
// Machine controller inputs and operator parameter writes, driven by task
module dacc_host_model
  import dacc_pkg::*;
(
  // Clock
  input  wire logic      clk,
  // Drive side
  output dacc_ctrl_t     ctrl,
  output dacc_param_wr_t param_wr
);
  // ****************************************************************
  // Idle levels
  // ****************************************************************
  // Servo on and supply good, so no servo-off edge is seen before a test asks for it
  initial begin
    ctrl            = '0;
    ctrl.servo_on   = 1'b1;
    ctrl.voltage_ok = 1'b1;
    param_wr        = '0;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Everything changes just after the rising edge
  task automatic step();
    @(posedge clk);
    #1;
  endtask

  // Alarm reset as a one-cycle pulse, giving a single rising edge
  task automatic pulse_arst();
    ctrl.alarm_reset_input = 1'b1;
    step();
    ctrl.alarm_reset_input = 1'b0;
  endtask

  // Power-on initialisation event
  task automatic pulse_init();
    ctrl.power_on_init = 1'b1;
    step();
    ctrl.power_on_init = 1'b0;
  endtask

  // Adjustment completes once the connector has been pulled
  task automatic adjust_done();
    ctrl.auto_adjust_done = 1'b1;
    step();
    ctrl.auto_adjust_done = 1'b0;
  endtask

  // Level inputs in one go
  task automatic levels(input logic es, sv, su, vk, fw, rv);
    ctrl.emergency_stop_input = es;
    ctrl.servo_on             = sv;
    ctrl.startup_phase        = su;
    ctrl.voltage_ok           = vk;
    ctrl.motor_moving_fwd     = fw;
    ctrl.motor_moving_rev     = rv;
  endtask

  // One parameter write; data is scrambled afterwards so stale data never helps
  task automatic write_param(input logic fopt, input logic [PARAM_W-1:0] d);
    param_wr.data                = d;
    param_wr.fault_option_wr     = fopt;
    param_wr.special_function_wr = !fopt;
    step();
    param_wr.fault_option_wr     = 1'b0;
    param_wr.special_function_wr = 1'b0;
    param_wr.data                = ~d;
  endtask

  // Parameter reset, then servo off and on again
  task automatic nvm_recover();
    ctrl.param_reset_done = 1'b1;
    step();
    ctrl.param_reset_done = 1'b0;
    ctrl.servo_on         = 1'b0;
    step();
    ctrl.servo_on         = 1'b1;
  endtask

  // Two special writes in the one order that arms the clear
  task automatic fw_unlock();
    write_param(1'b0, SFP_FW_STEP1);
    step();
    write_param(1'b0, SFP_FW_STEP2);
  endtask
endmodule

// ---- test/drive_alarm_clear_controller_tb.sv ----
`timescale 1ns/1ps
// Self-checking bench for the alarm clearing controller
module drive_alarm_clear_controller_tb
  import dacc_pkg::*;
;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic                  clk = 1'b0;      // 200 MHz
  logic                  rst = 1'b1;      // Synchronous, high
  logic [NUM_ALARMS-1:0] fault_detect = '0;
  dacc_ctrl_t            ctrl;
  dacc_param_wr_t        param_wr;
  logic [NUM_ALARMS-1:0] alarm_latched;
  logic [CODE_W-1:0]     alarm_code_reg;
  logic                  alarm_active_reg;
  logic [PARAM_W-1:0]    fault_option_reg;
  int                    n_fail = 0;
  int                    checks_done = 0;
  logic [31:0]           seed = 32'd89;   // Fixed, so runs repeat

  always #2.5 clk = ~clk;

  dacc_host_model i_dacc_host_model (.clk(clk), .ctrl(ctrl), .param_wr(param_wr));

  dacc_clear_ctrl i_dacc_clear_ctrl (
    .clk(clk), .rst(rst), .fault_detect(fault_detect), .ctrl(ctrl),
    .param_wr(param_wr), .alarm_latched(alarm_latched),
    .alarm_code_reg(alarm_code_reg), .alarm_active_reg(alarm_active_reg),
    .fault_option_reg(fault_option_reg));

  // ****************************************************************
  // Expectations by displayed code
  // ****************************************************************
  // Cleared by an alarm reset edge (start-up memory case handled apart)
  function automatic logic arst_clr(input int s);
    return !(ALARM_CODE[s] inside {4, 11, [24:29], 31, 35, 12, 99, 555, 880});
  endfunction

  // Cleared by power-on initialisation
  function automatic logic init_clr(input int s);
    return ALARM_CODE[s] inside {2, 4, 11, [24:29], 31, 35};
  endfunction

  // Follows its cause level
  function automatic logic self_clr(input int s);
    return ALARM_CODE[s] inside {13, 67};
  endfunction

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic step();
    @(posedge clk);
    #1;
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Valid only while at most this one slot can be latched
  task automatic chk_slot(input int s, input logic exp);
    check(alarm_latched[s], exp);
    check(alarm_code_reg, exp ? ALARM_CODE[s] : CODE_NONE);
    check(alarm_active_reg, exp);
  endtask

  // Fault pulse, then one edge so code and active have landed
  task automatic raise(input int s);
    fault_detect[s] = 1'b1;
    step();
    fault_detect[s] = 1'b0;
    step();
  endtask

  // rst clears every alarm, including the ones that never clear otherwise
  task automatic reset_dut();
    rst = 1'b1;
    repeat (10) step();
    rst = 1'b0;
    step();
    check(alarm_latched, '0);
  endtask

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Watchdog: the sequence needs about 430 cycles
  // ****************************************************************
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    int a;
    int b;
    reset_dut();
    // Every slot against alarm reset, then init if it survives, then adjustment or firmware clear; self-clearing slots by cause
    for (int s = 0; s < NUM_ALARMS; s++) begin
      if (self_clr(s)) begin
        fault_detect[s] = 1'b1;
        step();
        step();
        chk_slot(s, 1'b1);
        fault_detect[s] = 1'b0;
        step();
        step();
        chk_slot(s, 1'b0);
      end else begin
        raise(s);
        chk_slot(s, 1'b1);
        i_dacc_host_model.pulse_arst();
        step();
        chk_slot(s, !arst_clr(s));
        if (!arst_clr(s)) begin
          i_dacc_host_model.pulse_init();
          step();
          chk_slot(s, !init_clr(s));
        end
        if (s == S_ADJUST) begin
          i_dacc_host_model.adjust_done();
          step();
          chk_slot(s, 1'b0);
        end
        if (s == S_FWUP) begin
          i_dacc_host_model.write_param(1'b0, SFP_FW_STEP2);
          i_dacc_host_model.pulse_init();
          step();
          chk_slot(s, 1'b1);
          i_dacc_host_model.fw_unlock();
          i_dacc_host_model.pulse_init();
          step();
          chk_slot(s, 1'b0);
        end
      end
      // Processor errors stay forever; clear them out of the way
      if (s >= S_PROC_A) reset_dut();
    end
    // Two random reset-class alarms at once: lowest slot shows
    for (int t = 0; t < 30; t++) begin
      do a = int'(rnd() % NUM_ALARMS); while (!arst_clr(a) || self_clr(a));
      do b = int'(rnd() % NUM_ALARMS); while (!arst_clr(b) || self_clr(b) || b == a);
      repeat (rnd() % 4) step();
      fault_detect[a] = 1'b1;
      fault_detect[b] = 1'b1;
      step();
      fault_detect = '0;
      step();
      check(alarm_code_reg, ALARM_CODE[(a < b) ? a : b]);
      i_dacc_host_model.pulse_arst();
      step();
      check(alarm_latched, '0);
      check(alarm_active_reg, 1'b0);
    end
    // Over-voltage also clears at initialisation
    raise(S_OVERVOLT);
    i_dacc_host_model.pulse_init();
    step();
    chk_slot(S_OVERVOLT, 1'b0);
    // Emergency stop input drives its own alarm
    i_dacc_host_model.levels(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    step();
    step();
    chk_slot(S_EMGS, 1'b1);
    i_dacc_host_model.levels(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    step();
    step();
    chk_slot(S_EMGS, 1'b0);
    // Limits: toward keeps, away clears, servo off clears
    for (int k = 0; k < 2; k++) begin
      a = k ? S_FWDLIM : S_REVLIM;
      raise(a);
      i_dacc_host_model.levels(1'b0, 1'b1, 1'b0, 1'b1, k[0], !k[0]);
      step();
      step();
      chk_slot(a, 1'b1);
      i_dacc_host_model.levels(1'b0, 1'b1, 1'b0, 1'b1, !k[0], k[0]);
      step();
      step();
      chk_slot(a, 1'b0);
      i_dacc_host_model.levels(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
      raise(a);
      i_dacc_host_model.levels(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      step();
      step();
      chk_slot(a, 1'b0);
      i_dacc_host_model.levels(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    end
    // Start-up memory alarm ignores alarm reset until recovery
    i_dacc_host_model.levels(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    raise(S_NVM);
    i_dacc_host_model.levels(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    i_dacc_host_model.pulse_arst();
    step();
    chk_slot(S_NVM, 1'b1);
    i_dacc_host_model.nvm_recover();
    step();
    step();
    chk_slot(S_NVM, 1'b0);
    // Option bit enables under-voltage self clear
    b = int'(16'(rnd()) | 16'h0004);
    i_dacc_host_model.write_param(1'b1, 16'(b));
    step();
    check(fault_option_reg, b);
    i_dacc_host_model.levels(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    raise(S_UNDERVOLT);
    chk_slot(S_UNDERVOLT, 1'b1);
    i_dacc_host_model.levels(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    step();
    step();
    chk_slot(S_UNDERVOLT, 1'b0);
    report_and_stop();
  end
endmodule
